// >>> rtl/rscmb_top.sv
// Functional notes
// - low-power detector undervoltage holds the system in reset.
// - both brown-out sources clear one shared brown-out cause flag.
// - low-power detector enabled only by config bit; erased means off.
// - or both brown-out requests into one generic brown-out reset.
// - pin function on if low-voltage programming set, else follows pin enable.
// - enabled pin held low keeps the device in reset.
// - filter ignores short low pulses on the reset pin.
// - no reset source drives the reset pin; it is input only.
// - disabled pin is a general input with software pull-up.
// - after release wait for timers and the pin before running.
// - run ten cycles after pin release when timers done.
// - reset instruction resets device and clears reset-instruction flag.
`include "rscmb_regs.svh"
module rscmb_top
  import rscmb_pkg::*;
#(
  parameter int FILT_CYC  = `RSCMB_FILT_CYC,
  parameter int START_CYC = `RSCMB_START_CYC
) (
  input  wire logic       clk_sys,
  input  wire logic       nrst,
  input  wire rscmb_cfg_t cfg,
  input  wire rscmb_src_t src,
  input  wire logic       pwrt_done,
  input  wire logic       ost_done,
  input  wire logic       reset_pin_in,
  output logic            reset_pin_out,
  output logic            reset_pin_oe,
  output logic            reset_pin_pullup,
  output logic            gpio_in,
  output logic            generic_bor,
  output logic            sys_reset,
  output logic            cpu_run,
  output logic            irq,
  input  wire logic [9:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic [31:0]     rdata
);
  localparam int SW = $clog2(START_CYC + 1);
  logic [1:0]              async_s;
  logic                    pin_low_s;
  logic                    pin_held;
  logic [7:0]              cause_q;
  logic [`RSCMB_IRQ_W-1:0] stat_q;
  logic [`RSCMB_IRQ_W-1:0] mask_q;
  logic                    pullup_q;
  logic                    swrst_q;
  logic [SW-1:0]           cnt_q;
  rscmb_state_t            st_q;
  rscmb_state_t            st_d;
  logic                    bor_hold_q;
  logic                    pin_rst_q;

  // source combination
  wire low_power_brownout_detector_w    = cfg.low_power_brownout_detector_en & async_s[1];
  wire gbor_w     = low_power_brownout_detector_w | async_s[0];
  wire pin_en_w   = cfg.lvp_en | cfg.pin_en;
  wire pin_rst_w  = pin_en_w & pin_held;
  wire pin_wait_w = pin_en_w & pin_low_s;
  wire hard_w     = gbor_w | src.por_req;
  wire soft_w     = src.wdt_req | src.stk_ovf | src.stk_unf | src.reset_instr | swrst_q;
  wire any_rst_w  = hard_w | soft_w | pin_rst_w;

  // pin inverted so a cleared flop reads as a released pin, no false low after reset
  rscmb_sync #(.W(3)) u_sync (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .d       ({~reset_pin_in, src.low_power_brownout_detector_req, src.bor_req}),
    .q       ({pin_low_s, async_s})
  );

  // noise filter on the synchronised low level
  rscmb_filter #(.N(FILT_CYC)) u_filt (
    .clk_sys  (clk_sys),
    .nrst     (nrst),
    .pin_low  (pin_en_w & pin_low_s),
    .held_low (pin_held)
  );

  // bus decode
  wire sel_cause = (addr == `RSCMB_ADDR_CAUSE);
  wire sel_stat  = (addr == `RSCMB_ADDR_IRQ_STAT);
  wire sel_mask  = (addr == `RSCMB_ADDR_IRQ_MASK);
  wire sel_ctrl  = (addr == `RSCMB_ADDR_CTRL);
  wire wr_cause  = wr & sel_cause;
  wire wr_stat   = wr & sel_stat;
  wire wr_mask   = wr & sel_mask;
  wire wr_ctrl   = wr & sel_ctrl;
  wire [7:0] rd_w = sel_cause ? cause_q :
                    sel_stat  ? {5'h00, stat_q} :
                    sel_mask  ? {5'h00, mask_q} :
                    sel_ctrl  ? {6'h00, 1'b0, pullup_q} : 8'h00;

  // interrupt events and register next values; a new event beats a clear
  wire [`RSCMB_IRQ_W-1:0] ev_w   = {src.reset_instr, pin_rst_w & ~pin_rst_q,
                                    gbor_w & ~bor_hold_q};
  wire [`RSCMB_IRQ_W-1:0] clr_w  = wr_stat ? wdata[`RSCMB_IRQ_W-1:0] : '0;
  wire [`RSCMB_IRQ_W-1:0] stat_d = (stat_q & ~clr_w) | ev_w;
  wire [`RSCMB_IRQ_W-1:0] mask_d = wr_mask ? wdata[`RSCMB_IRQ_W-1:0] : mask_q;
  wire pullup_d = wr_ctrl ? wdata[`RSCMB_CTRL_PULLUP] : pullup_q;
  wire swrst_d  = wr_ctrl & wdata[`RSCMB_CTRL_SWRST];

  // cause flags: active low except the two stack flags, which set high; a hardware clear wins over a re-arm write
  wire [7:0] cause_sw_w  = wr_cause ? ((cause_q & ~`RSCMB_CAUSE_WMASK) |
                                       (wdata & `RSCMB_CAUSE_WMASK)) : cause_q;
  wire [7:0] cause_clr_w = {3'h0, src.wdt_req, pin_rst_w,
                            src.reset_instr, 1'b0, gbor_w};
  wire [7:0] cause_set_w = {src.stk_ovf, src.stk_unf, 6'h00};
  wire [7:0] cause_d     = (cause_sw_w & ~cause_clr_w) | cause_set_w;

  // start-up sequencer
  always_comb begin
    st_d = st_q;
    case (st_q)
      RSCMB_HOLD: begin
        if (!any_rst_w && pwrt_done && ost_done) begin
          st_d = RSCMB_WAIT_PIN;
        end
      end
      RSCMB_WAIT_PIN: begin
        if (any_rst_w) begin
          st_d = RSCMB_HOLD;
        end else if (!pin_wait_w) begin
          st_d = RSCMB_COUNT;
        end
      end
      RSCMB_COUNT: begin
        if (any_rst_w) begin
          st_d = RSCMB_HOLD;
        end else if (cnt_q == SW'(START_CYC - 1)) begin
          st_d = RSCMB_RUN;
        end
      end
      RSCMB_RUN: begin
        if (any_rst_w) begin
          st_d = RSCMB_HOLD;
        end
      end
      default: begin
        st_d = RSCMB_HOLD;
      end
    endcase
  end

  // start delay counter next value
  wire [SW-1:0] cnt_d = (st_q == RSCMB_COUNT) ? cnt_q + 1'b1 : '0;

  // output next values
  wire [31:0] rdata_d = rd ? {24'h00_0000, rd_w} : 32'h0000_0000;
  wire        run_d   = (st_d == RSCMB_RUN);
  wire        srst_d  = any_rst_w | ~run_d;
  wire        irq_d   = |(stat_q & mask_q);
  wire        gpio_d  = pin_en_w ? 1'b0 : ~pin_low_s;
  wire        pull_d  = pin_en_w ? 1'b1 : pullup_q;

  // cause flags
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cause_q <= `RSCMB_CAUSE_RST;
    end else begin
      cause_q <= cause_d;
    end
  end

  // interrupt status
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      stat_q <= '0;
    end else begin
      stat_q <= stat_d;
    end
  end

  // interrupt mask
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      mask_q <= '0;
    end else begin
      mask_q <= mask_d;
    end
  end

  // software pull-up for the general input mode
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pullup_q <= 1'b1;
    end else begin
      pullup_q <= pullup_d;
    end
  end

  // one-cycle software reset request
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      swrst_q <= 1'b0;
    end else begin
      swrst_q <= swrst_d;
    end
  end

  // sequencer state
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st_q <= RSCMB_HOLD;
    end else begin
      st_q <= st_d;
    end
  end

  // start delay counter
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // brown-out history for the rising edge event
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      bor_hold_q <= 1'b0;
    end else begin
      bor_hold_q <= gbor_w;
    end
  end

  // pin reset history for the rising edge event
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pin_rst_q <= 1'b0;
    end else begin
      pin_rst_q <= pin_rst_w;
    end
  end

  // read data, one cycle after the strobe, else zero
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rdata <= '0;
    end else begin
      rdata <= rdata_d;
    end
  end

  // generic brown-out level
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      generic_bor <= 1'b0;
    end else begin
      generic_bor <= gbor_w;
    end
  end

  // system reset level
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sys_reset <= 1'b1;
    end else begin
      sys_reset <= srst_d;
    end
  end

  // start-up done
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cpu_run <= 1'b0;
    end else begin
      cpu_run <= run_d;
    end
  end

  // level interrupt
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      irq <= 1'b0;
    end else begin
      irq <= irq_d;
    end
  end

  // general input level while the reset function is off
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      gpio_in <= 1'b0;
    end else begin
      gpio_in <= gpio_d;
    end
  end

  // pull-up control of the pin
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      reset_pin_pullup <= 1'b1;
    end else begin
      reset_pin_pullup <= pull_d;
    end
  end

  // the pin is never driven by any reset source
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      reset_pin_out <= 1'b0;
      reset_pin_oe  <= 1'b0;
    end else begin
      reset_pin_out <= 1'b0;
      reset_pin_oe  <= 1'b0;
    end
  end
endmodule

// >>> pkg/rscmb_regs.svh
`ifndef RSCMB_REGS_SVH
`define RSCMB_REGS_SVH
// register byte addresses (printed offset 0x096 is not a multiple of four, so index*4)
`define RSCMB_IDX_CAUSE      8'h96
`define RSCMB_ADDR_CAUSE     10'h0258
`define RSCMB_ADDR_IRQ_STAT  10'h0260
`define RSCMB_ADDR_IRQ_MASK  10'h0264
`define RSCMB_ADDR_CTRL      10'h0268
// reset cause flag bit positions
`define RSCMB_BIT_STKOVF     7
`define RSCMB_BIT_STKUNF     6
`define RSCMB_BIT_RWDT       4
`define RSCMB_BIT_RPIN       3
`define RSCMB_BIT_RI         2
`define RSCMB_BIT_POR        1
`define RSCMB_BIT_BOR        0
// cause register value loaded by nrst at power-on; a brown-out only clears the BOR bit
`define RSCMB_CAUSE_RST      8'h1c
// writable mask of cause register
`define RSCMB_CAUSE_WMASK    8'hdf
// interrupt status bit positions
`define RSCMB_IRQ_BOR        0
`define RSCMB_IRQ_PIN        1
`define RSCMB_IRQ_RI         2
`define RSCMB_IRQ_W          3
// control register bits
`define RSCMB_CTRL_PULLUP    0
`define RSCMB_CTRL_SWRST     1
// timing
`define RSCMB_FILT_CYC       8
`define RSCMB_START_CYC      10
`endif

// >>> pkg/rscmb_pkg.sv
package rscmb_pkg;
  // static configuration word bits
  typedef struct packed {
    logic low_power_brownout_detector_en;
    logic pin_en;
    logic lvp_en;
  } rscmb_cfg_t;
  // reset sources from analog side and core
  typedef struct packed {
    logic low_power_brownout_detector_req;
    logic bor_req;
    logic por_req;
    logic wdt_req;
    logic stk_ovf;
    logic stk_unf;
    logic reset_instr;
  } rscmb_src_t;
  typedef enum logic [1:0] {
    RSCMB_HOLD,
    RSCMB_WAIT_PIN,
    RSCMB_COUNT,
    RSCMB_RUN
  } rscmb_state_t;
endpackage

// >>> rtl/rscmb_sync.sv
module rscmb_sync
  import rscmb_pkg::*;
#(
  parameter int W = 1
) (
  input  wire logic         clk_sys,
  input  wire logic         nrst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] s1_q;
  // two-stage synchroniser, first stage read only by second
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      s1_q <= '0;
      q    <= '0;
    end else begin
      s1_q <= d;
      q    <= s1_q;
    end
  end
endmodule

// >>> rtl/rscmb_filter.sv
`include "rscmb_regs.svh"
module rscmb_filter
  import rscmb_pkg::*;
#(
  parameter int N = `RSCMB_FILT_CYC
) (
  input  wire logic clk_sys,
  input  wire logic nrst,
  input  wire logic pin_low,
  output logic      held_low
);
  localparam int CW = $clog2(N + 1);
  logic [CW-1:0] cnt_q;
  // accept low only after N+1 stable cycles; any high restarts
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cnt_q    <= '0;
      held_low <= 1'b0;
    end else if (!pin_low) begin
      cnt_q    <= '0;
      held_low <= 1'b0;
    end else if (cnt_q != CW'(N)) begin
      cnt_q    <= cnt_q + 1'b1;
    end else begin
      held_low <= 1'b1;
    end
  end
endmodule

// >>> bench/rscmb_top_asserts.sv
`include "rscmb_regs.svh"
module rscmb_top_asserts
  import rscmb_pkg::*;
#(
  parameter int FILT_CYC = `RSCMB_FILT_CYC
) (
  input wire logic        clk_sys,
  input wire logic        nrst,
  input wire rscmb_cfg_t  cfg,
  input wire rscmb_src_t  src,
  input wire logic        reset_pin_in,
  input wire logic        reset_pin_out,
  input wire logic        reset_pin_oe,
  input wire logic        reset_pin_pullup,
  input wire logic        gpio_in,
  input wire logic        generic_bor,
  input wire logic        sys_reset,
  input wire logic        cpu_run,
  input wire logic        rd,
  input wire logic [31:0] rdata
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  wire        pin_en = cfg.lvp_en | cfg.pin_en;
  logic [7:0] low_q;
  // length of the current enabled low run on the pin
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) low_q <= 8'h00;
    else low_q <= (pin_en && !reset_pin_in) ? low_q + 8'h01 : 8'h00;
  end
  AST_PIN_IN_ONLY: assert property (!reset_pin_oe && !reset_pin_out)
    else $error("reset pin driven");
  AST_BOR_OR: assert property (src.bor_req [*5] |-> generic_bor)
    else $error("main brown-out lost");
  AST_LP_ON: assert property ((cfg.low_power_brownout_detector_en && src.low_power_brownout_detector_req) [*5] |-> generic_bor)
    else $error("low-power brown-out lost");
  AST_LP_OFF: assert property ((!cfg.low_power_brownout_detector_en && !src.bor_req) [*5] |-> !generic_bor)
    else $error("disabled detector acts");
  AST_BOR_HOLD: assert property (generic_bor [*2] |-> sys_reset)
    else $error("brown-out not held");
  AST_PIN_RESET: assert property (low_q > FILT_CYC + 5 |-> sys_reset)
    else $error("pin low not held");
  AST_PIN_CFG: assert property (pin_en [*2] |-> reset_pin_pullup && !gpio_in)
    else $error("enabled pin state");
  AST_GPIO: assert property ((!pin_en && reset_pin_in) [*5] |-> gpio_in)
    else $error("gpio level lost");
  AST_RD_IDLE: assert property (!$past(rd) |-> rdata == 32'h0000_0000)
    else $error("rdata not idle");
  AST_RUN_EXCL: assert property (cpu_run |-> !sys_reset)
    else $error("run during reset");
  AST_RI: assert property (src.reset_instr |-> ##[1:3] sys_reset)
    else $error("reset instr ignored");
endmodule
bind rscmb_top rscmb_top_asserts #(.FILT_CYC(FILT_CYC)) i_rscmb_top_asserts (
  .clk_sys, .nrst, .cfg, .src, .reset_pin_in, .reset_pin_out, .reset_pin_oe,
  .reset_pin_pullup, .gpio_in, .generic_bor, .sys_reset, .cpu_run, .rd, .rdata);

// >>> bench/rscmb_ext.sv
module rscmb_ext (
  input  wire logic hold_low,
  input  wire logic uv_lp,
  input  wire logic uv_main,
  output logic      pin,
  output logic      lp_req,
  output logic      main_req
);
  timeunit 1ns;
  timeprecision 1ns;
  // pin rests on its pull-up unless held low
  assign pin = hold_low ? 1'h0 : 1'h1;
  // supply monitor requests follow undervoltage
  assign lp_req = uv_lp;
  assign main_req = uv_main;
endmodule

// >>> bench/tb.sv
`include "rscmb_regs.svh"
module tb import rscmb_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int FC = 4;
  logic        clk_sys = 1'h0, nrst = 1'h0, pwrt_done = 1'h1, ost_done = 1'h1, ri = 1'h0;
  logic [3:0]  misc = 4'h0;
  logic        hold_low = 1'h0, uv_lp = 1'h0, uv_main = 1'h0, wr = 1'h0, rd = 1'h0;
  rscmb_cfg_t  cfg = 3'h0;
  logic [9:0]  addr = 10'h000;
  logic [7:0]  wdata = 8'h00;
  logic        pin, lp_req, main_req, pout, poe, pull, gpio, gbor, srst, run, irq;
  logic [31:0] rdata, d;
  int          n_mismatch = 0, total_checks = 0;
  wire rscmb_src_t src_w = {lp_req, main_req, misc, ri};
  always #25 clk_sys = ~clk_sys;
  rscmb_ext i_rscmb_ext (.hold_low, .uv_lp, .uv_main, .pin, .lp_req, .main_req);
  rscmb_top #(.FILT_CYC(FC)) i_rscmb_top (
    .clk_sys, .nrst, .cfg, .src(src_w), .pwrt_done, .ost_done,
    .reset_pin_in(pin), .reset_pin_out(pout), .reset_pin_oe(poe),
    .reset_pin_pullup(pull), .gpio_in(gpio), .generic_bor(gbor),
    .sys_reset(srst), .cpu_run(run), .irq, .addr, .wdata, .wr, .rd, .rdata);
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic bw(input logic [9:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    addr <= a;
    wdata <= v;
    wr <= 1'h1;
    @(posedge clk_sys) wr <= 1'h0;
  endtask
  task automatic br(input logic [9:0] a);
    @(posedge clk_sys);
    addr <= a;
    rd <= 1'h1;
    @(posedge clk_sys) rd <= 1'h0;
    #1 d = rdata;
  endtask
  task automatic wait_run;
    for (int i = 0; i < 100 && run !== 1'h1; i++) cyc(1);
  endtask
  task automatic t_bor;
    br(`RSCMB_ADDR_CAUSE);
    chk("cause rst", {24'h00_0000, `RSCMB_CAUSE_RST}, d);
    br(10'h0300);
    chk("unmapped", 32'h0000_0000, d);
    @(posedge clk_sys) uv_lp <= 1'h1;
    cyc(8);
    chk("lp off", 32'h0000_0000, gbor);
    @(posedge clk_sys) cfg.low_power_brownout_detector_en <= 1'h1;
    cyc(8);
    chk("lp gbor", 32'h0000_0001, gbor);
    chk("lp hold", 32'h0000_0001, srst);
    @(posedge clk_sys) uv_lp <= 1'h0;
    wait_run;
    br(`RSCMB_ADDR_CAUSE);
    chk("lp flag", 32'h0000_0000, d[`RSCMB_BIT_BOR]);
    bw(`RSCMB_ADDR_CAUSE, 8'h1f);
    @(posedge clk_sys) uv_main <= 1'h1;
    cyc(8);
    chk("bor gbor", 32'h0000_0001, gbor);
    @(posedge clk_sys) uv_main <= 1'h0;
    wait_run;
    br(`RSCMB_ADDR_CAUSE);
    chk("bor flag", 32'h0000_0000, d[`RSCMB_BIT_BOR]);
    chk("irq masked", 32'h0000_0000, irq);
    bw(`RSCMB_ADDR_IRQ_MASK, 8'h01);
    cyc(2);
    chk("irq", 32'h0000_0001, irq);
    bw(`RSCMB_ADDR_IRQ_STAT, 8'h01);
    cyc(2);
    chk("irq clr", 32'h0000_0000, irq);
    $display("t_bor done");
  endtask
  task automatic t_pin;
    for (int m = 0; m < 4; m++) begin
      @(posedge clk_sys) cfg <= {1'h1, m[0], m[1]};
      hold_low <= 1'h1;
      cyc(FC + 8);
      chk("pin rst", m != 0, srst);
      chk("gpio low", 32'h0000_0000, gpio);
      chk("pullup", 32'h0000_0001, pull);
      chk("pin idle", 32'h0000_0000, {poe, pout});
      @(posedge clk_sys) hold_low <= 1'h0;
      wait_run;
    end
    @(posedge clk_sys) cfg <= 3'h4;
    bw(`RSCMB_ADDR_CTRL, 8'h00);
    cyc(6);
    chk("gpio high", 32'h0000_0001, gpio);
    chk("pull sw", 32'h0000_0000, pull);
    bw(`RSCMB_ADDR_CTRL, 8'h03);
    cyc(2);
    chk("sw rst", 32'h0000_0001, srst);
    wait_run;
    $display("t_pin done");
  endtask
  task automatic t_start;
    int n;
    @(posedge clk_sys) cfg <= 3'h6;
    hold_low <= 1'h1;
    repeat (FC - 1) @(posedge clk_sys);
    hold_low <= 1'h0;
    cyc(FC + 6);
    chk("glitch", 32'h0000_0000, srst);
    @(posedge clk_sys) hold_low <= 1'h1;
    pwrt_done <= 1'h0;
    cyc(20);
    @(posedge clk_sys) hold_low <= 1'h0;
    cyc(20);
    chk("timer wait", 32'h0000_0000, run);
    @(posedge clk_sys) pwrt_done <= 1'h1;
    ost_done <= 1'h0;
    cyc(20);
    chk("osc wait", 32'h0000_0000, run);
    @(posedge clk_sys) ost_done <= 1'h1;
    wait_run;
    @(posedge clk_sys) hold_low <= 1'h1;
    cyc(20);
    @(posedge clk_sys) hold_low <= 1'h0;
    for (n = 0; n < 40 && run !== 1'h1; n++) cyc(1);
    chk("start", 32'h0000_0001, n >= `RSCMB_START_CYC && n <= `RSCMB_START_CYC + 6);
    @(posedge clk_sys) ri <= 1'h1;
    @(posedge clk_sys) ri <= 1'h0;
    cyc(2);
    chk("ri rst", 32'h0000_0001, srst);
    wait_run;
    br(`RSCMB_ADDR_CAUSE);
    chk("ri flag", 32'h0000_0000, d[`RSCMB_BIT_RI]);
    @(posedge clk_sys) misc <= 4'h6;
    @(posedge clk_sys) misc <= 4'h0;
    cyc(2);
    chk("wdt rst", 32'h0000_0001, srst);
    wait_run;
    br(`RSCMB_ADDR_CAUSE);
    chk("wdt flag", 32'h0000_0000, d[`RSCMB_BIT_RWDT]);
    chk("stk flag", 32'h0000_0001, d[`RSCMB_BIT_STKOVF]);
    $display("t_start done");
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk_sys);
    nrst <= 1'h1;
    cyc(2);
    t_bor;
    t_pin;
    t_start;
    tally_and_finish;
  end
  initial begin
    #1_000_000;
    n_mismatch++;
    tally_and_finish;
  end
endmodule
